// [hw/adcp_pkg.sv]
// Constants and carrier types for the audio descriptor engine and codec port.
// Assumes a byte-offset register port and a serializer on the codec clock.
// How it works
// - Engine walks descriptors, refetches each, no cache
// - Descriptor: pointer word, then count plus flags
// - Bit 31 marks the last descriptor
// - End-of-page completion sets status bit 0, interrupt if bit 0 was clear
// - Second end-of-page sets error, pauses; read resumes
// - Jump descriptor moves nothing, reloads table address
// - Descriptor is 8 bytes, at most 64KB
// - Fetch at table address, then add 08h
// - Each frame request moves one sample
// - Status word reloads when slots 1 and 2 are both valid
// - Status data and address come from slots 2,1
// - Command address goes out in slot 1
// - Command valid set on load, cleared when sent
// - Bits 23:22 pick the codec
// - Bits 20/19 steer engine slots 6 or 11
// - GPIO control out, GPIO status in, slot 12
// - Bit 30 is the end-of-page flag
// - Direction bit 3: 0 read, 1 write
package adcp_pkg;
   localparam logic [7:0]  OFS_GPIO_STAT = 8'h00;        // Codec GPIO status
   localparam logic [7:0]  OFS_GPIO_CTL  = 8'h04;        // Codec GPIO control
   localparam logic [7:0]  OFS_CDC_STAT  = 8'h08;        // Codec status word
   localparam logic [7:0]  OFS_CDC_CMD   = 8'h0c;        // Codec command word
   localparam logic [7:0]  OFS_ENG_CTL   = 8'h20;        // Engine command [7:0], status [15:8]
   localparam logic [7:0]  OFS_ENG_TBL   = 8'h24;        // Descriptor table address
   localparam logic [31:0] RST_GPIO_STAT = 32'h0010_0000;
   localparam logic [31:0] RST_ZERO      = 32'h0000_0000;
   localparam int          B_EOT         = 31;           // Descriptor word 1 flags
   localparam int          B_EOP         = 30;
   localparam int          B_JMP         = 29;
   localparam int          B_ENA         = 0;            // Engine command bits
   localparam int          B_DIR         = 3;
   localparam int          B_ST_EOP      = 0;            // Engine status bits
   localparam int          B_ST_ERR      = 1;
   localparam int          B_GPIO_NVLD   = 20;           // GPIO status: 1 = not valid
   localparam int          B_RX_SLOT     = 20;           // Codec status: engine 5 slot
   localparam int          B_TX_SLOT     = 19;           // Codec status: engine 4 slot
   localparam int          B_TAG_NEW     = 17;
   localparam int          B_STAT_VLD    = 16;
   localparam int          B_CMD_VLD     = 16;
   localparam logic [31:0] DESC_STEP     = 32'h0000_0008;
   localparam logic [16:0] FULL_PAGE     = 17'h1_0000;   // Count 0 means 64KB
   localparam logic [16:0] SMP_BYTES     = 17'h0_0002;   // One 16-bit sample
   localparam logic [31:0] CDC_STAT_WMSK = 32'h00f8_0000; // Writable bits 23:19
   localparam logic [31:0] GPIO_ST_WMSK  = 32'hc000_0000; // Writable bits 31:30

   // Frame as received by the serializer, one bundle per frame
   typedef struct packed {
      logic        s1_vld;   // Slot 1 (status address) tagged valid
      logic        s2_vld;   // Slot 2 (status data) tagged valid
      logic        s12_vld;  // Slot 12 (GPIO) tagged valid
      logic [19:0] s1;
      logic [19:0] s2;
      logic [19:0] s12;
      logic [19:0] smp;      // Input sample from the selected slot
   } adcp_rx_t;

   // Words handed to the serializer for the next frame
   typedef struct packed {
      logic        cmd_vld;  // Control slots carry a command this frame
      logic [7:0]  cmd_addr; // Slot 1 bits 19:12
      logic [1:0]  cmd_cdc;  // Target codec
      logic [15:0] cmd_data;
      logic [19:0] gpio;     // Slot 12
      logic [15:0] smp;      // Output sample
      logic        tx_s11;   // Output sample in slot 11, else 6
      logic        rx_s11;   // Input sample from slot 11, else 6
   } adcp_tx_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_FETCH0, ST_FETCH1, ST_DECODE, ST_WAIT, ST_MEM, ST_PAUSE, ST_DONE
   } adcp_state_t;
endpackage : adcp_pkg

// [hw/adcp_top.sv]
// Descriptor-driven audio engine with the codec register port.
// Registers sit behind a simple byte-offset port on clk; memory is a
// request/acknowledge master; the link side runs on the codec bit clock.
`timescale 1ns/10ps
module adcp_top
   import adcp_pkg::*;
(
   input  wire logic        clk,           // System clock
   input  wire logic        sys_rst,       // Asynchronous reset, high
   input  wire logic [7:0]  reg_addr,      // Byte offset
   input  wire logic        reg_wr,        // Write strobe
   input  wire logic        reg_rd,        // Read strobe
   input  wire logic [31:0] reg_wdata,
   output logic      [31:0] reg_rdata,     // Valid the cycle after reg_rd
   output logic             mem_req,       // Held until mem_ack while enabled
   output logic             mem_we,
   output logic      [31:0] mem_addr,
   output logic      [3:0]  mem_be,
   output logic      [31:0] mem_wdata,
   input  wire logic        mem_ack,
   input  wire logic [31:0] mem_rdata,
   output logic             mgmt_interrupt, // One-cycle pulse per end-of-page completion while status bit 0 is clear
   input  wire logic        bit_clk,       // Codec-driven link clock
   input  wire logic        lnk_frame,     // One bit_clk pulse per frame
   input  wire adcp_rx_t    lnk_rx,        // Valid with lnk_frame
   output adcp_tx_t         lnk_tx         // Taken by serializer at frame
);
   // System-side registers
   logic [31:0] gst_q, gctl_q, cst_q, cmd_q, tbl_q;
   logic [7:0]  ectl_q;                    // Engine command byte
   logic [1:0]  est_q;                     // Engine status: err, eop
   logic [31:0] rdata_q;
   adcp_state_t st_q;
   logic [31:0] ptr_q;                     // Buffer pointer of current descriptor
   logic [16:0] left_q;                    // Bytes left in descriptor
   logic        eot_q, eop_q, jmp_q;
   logic        mreq_q, mwe_q, irq_q;
   logic [31:0] maddr_q, mwd_q;
   logic [3:0]  mbe_q;
   logic        pend_q;                    // Sample request waiting
   logic [15:0] txs_q;                     // Output sample for the link
   logic [19:0] gsnap_q;                   // GPIO control held for the link
   logic        cmd_tgl_q;                 // Toggles on each command load
   logic        frm_s1_q, frm_s2_q, frm_s3_q, ack_s1_q, ack_s2_q;
   // Link-side registers
   logic        frm_tgl_q, cmd_ack_q;
   logic        ctg_s1_q, ctg_s2_q;
   logic [1:0]  sel_s1_q, sel_s2_q;
   adcp_rx_t    rx_q;
   adcp_tx_t    tx_q;

   // Register decode
   wire hit_gst  = reg_addr == OFS_GPIO_STAT;
   wire hit_gctl = reg_addr == OFS_GPIO_CTL;
   wire hit_cst  = reg_addr == OFS_CDC_STAT;
   wire hit_cmd  = reg_addr == OFS_CDC_CMD;
   wire hit_ectl = reg_addr == OFS_ENG_CTL;
   wire hit_tbl  = reg_addr == OFS_ENG_TBL;
   wire wr_cmd   = reg_wr & hit_cmd;
   wire rd_cst   = reg_rd & hit_cst;
   wire rd_est   = reg_rd & hit_ectl;     // Read of status clears it
   wire enabled  = ectl_q[B_ENA];
   wire dir_in   = ectl_q[B_DIR];
   wire frm_ev   = frm_s2_q ^ frm_s3_q;   // New frame seen on clk
   wire cmd_sent = ack_s2_q == cmd_tgl_q;
   wire rx_upd   = frm_ev & rx_q.s1_vld & rx_q.s2_vld;
   wire last_smp = left_q <= SMP_BYTES;
   wire page_end = (st_q == ST_MEM) & mem_ack & last_smp;
   wire eop_hit  = page_end & eop_q;
   wire eop_2nd  = eop_hit & est_q[B_ST_EOP];
   wire [31:0] rd_mux =
      hit_gst  ? gst_q :
      hit_gctl ? gctl_q :
      hit_cst  ? cst_q :
      hit_cmd  ? cmd_q :
      hit_ectl ? {16'h0000, 6'h00, est_q, ectl_q & 8'h09} :
      hit_tbl  ? tbl_q : RST_ZERO;      // Unmapped reads return zero
   // Half picked by the sample pointer, since the sample bus address is always word aligned
   wire [15:0] rd_half = ptr_q[1] ? mem_rdata[31:16] : mem_rdata[15:0];

   // Read data is registered so the port output comes from a flop
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) rdata_q <= RST_ZERO;
      else if (reg_rd) rdata_q <= rd_mux;
   end

   // Link-event synchronisers on clk; logic uses the second stage, frame edge also the third
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         {frm_s1_q, frm_s2_q, frm_s3_q, ack_s1_q, ack_s2_q} <= 5'h00;
      end else begin
         frm_s1_q <= frm_tgl_q;
         frm_s2_q <= frm_s1_q;
         frm_s3_q <= frm_s2_q;
         ack_s1_q <= cmd_ack_q;
         ack_s2_q <= ack_s1_q;
      end
   end

   // GPIO registers: control is plain, status mixes software and codec bits
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         gst_q  <= RST_GPIO_STAT;
         gctl_q <= RST_ZERO;
      end else begin
         if (reg_wr & hit_gctl) gctl_q <= {12'h000, reg_wdata[19:0]};
         if (reg_wr & hit_gst) gst_q <= (gst_q & ~GPIO_ST_WMSK) | (reg_wdata & GPIO_ST_WMSK);
         if (frm_ev & rx_q.s12_vld) begin
            gst_q[19:0]        <= rx_q.s12;
            gst_q[B_GPIO_NVLD] <= 1'b0;
         end
      end
   end

   // Codec status: received fields are read-only, bits 23:19 are software's
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) cst_q <= RST_ZERO;
      else begin
         if (reg_wr & hit_cst) cst_q <= (cst_q & ~CDC_STAT_WMSK) | (reg_wdata & CDC_STAT_WMSK);
         if (rx_upd) begin
            cst_q[31:24]      <= rx_q.s1[19:12];
            cst_q[15:0]       <= rx_q.s2[19:4];
            cst_q[B_STAT_VLD] <= 1'b1;
            cst_q[B_TAG_NEW]  <= 1'b1;
         end else if (rd_cst) begin
            cst_q[B_TAG_NEW]  <= 1'b0;         // Seen by software; a new word wins
         end
      end
   end

   // Command word: valid rises on load, falls once the link has sent it
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cmd_q     <= RST_ZERO;
         cmd_tgl_q <= 1'b0;
      end else if (wr_cmd) begin
         cmd_q     <= {reg_wdata[31:22], 5'h00, 1'b1, reg_wdata[15:0]};
         cmd_tgl_q <= ~cmd_tgl_q;
      end else if (cmd_sent) begin
         cmd_q[B_CMD_VLD] <= 1'b0;
      end
   end

   // Engine command byte and table address
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ectl_q <= 8'h00;
         tbl_q  <= RST_ZERO;
      end else begin
         if (reg_wr & hit_ectl) ectl_q <= reg_wdata[7:0] & 8'h09;
         if (reg_wr & hit_tbl) tbl_q <= {reg_wdata[31:2], 2'b00};
         else if (st_q == ST_FETCH0 && mem_ack) tbl_q <= tbl_q + DESC_STEP;
         else if (st_q == ST_DECODE && jmp_q) tbl_q <= ptr_q;
      end
   end

   // Engine status: hardware set wins over a clearing read
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) est_q <= 2'b00;
      else begin
         est_q[B_ST_EOP] <= eop_hit | (est_q[B_ST_EOP] & ~rd_est);
         est_q[B_ST_ERR] <= eop_2nd | (est_q[B_ST_ERR] & ~rd_est);
      end
   end

   // Frame requests queue one sample move; snapshots feed the link
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pend_q  <= 1'b0;
         gsnap_q <= 20'h00000;
      end else begin
         if (frm_ev) gsnap_q <= gctl_q[19:0];
         if (frm_ev) pend_q <= 1'b1;
         else if (st_q == ST_WAIT && pend_q) pend_q <= 1'b0;
      end
   end

   // Descriptor walk and sample moves
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q    <= ST_IDLE;
         ptr_q   <= RST_ZERO;
         left_q  <= 17'h0_0000;
         {eot_q, eop_q, jmp_q} <= 3'b000;
         {mreq_q, mwe_q, irq_q} <= 3'b000;
         maddr_q <= RST_ZERO;
         mwd_q   <= RST_ZERO;
         mbe_q   <= 4'h0;
         txs_q   <= 16'h0000;
      end else begin
         irq_q <= eop_hit & ~est_q[B_ST_EOP];
         if (!enabled) begin
            st_q   <= ST_IDLE;
            mreq_q <= 1'b0;
         end else begin
            case (st_q)
               ST_IDLE: begin
                  st_q    <= ST_FETCH0;
                  mreq_q  <= 1'b1;
                  mwe_q   <= 1'b0;
                  mbe_q   <= 4'hf;
                  maddr_q <= tbl_q;
               end
               ST_FETCH0: if (mem_ack) begin
                  ptr_q   <= mem_rdata;
                  maddr_q <= tbl_q + 32'h0000_0004;
                  st_q    <= ST_FETCH1;
               end
               ST_FETCH1: if (mem_ack) begin
                  mreq_q <= 1'b0;
                  eot_q  <= mem_rdata[B_EOT];
                  eop_q  <= mem_rdata[B_EOP];
                  jmp_q  <= mem_rdata[B_JMP];
                  left_q <= (mem_rdata[15:0] == 16'h0000) ? FULL_PAGE : {1'b0, mem_rdata[15:0]};
                  st_q   <= ST_DECODE;
               end
               ST_DECODE: begin
                  if (jmp_q) begin
                     st_q    <= ST_FETCH0;
                     mreq_q  <= 1'b1;
                     maddr_q <= ptr_q;
                  end else begin
                     st_q <= ST_WAIT;
                  end
               end
               ST_WAIT: if (pend_q) begin
                  st_q    <= ST_MEM;
                  mreq_q  <= 1'b1;
                  mwe_q   <= dir_in;
                  maddr_q <= {ptr_q[31:2], 2'b00};
                  mbe_q   <= ptr_q[1] ? 4'hc : 4'h3;
                  mwd_q   <= {rx_q.smp[19:4], rx_q.smp[19:4]};
               end
               ST_MEM: if (mem_ack) begin
                  mreq_q <= 1'b0;
                  mwe_q  <= 1'b0;
                  if (!dir_in) txs_q <= rd_half;
                  ptr_q  <= ptr_q + 32'h0000_0002;
                  left_q <= left_q - SMP_BYTES;
                  if (!last_smp) st_q <= ST_WAIT;
                  else if (eop_2nd) st_q <= ST_PAUSE;
                  else if (eot_q) st_q <= ST_DONE;
                  else begin
                     st_q    <= ST_FETCH0;
                     mreq_q  <= 1'b1;
                     mbe_q   <= 4'hf;
                     maddr_q <= tbl_q;
                  end
               end
               ST_PAUSE: if (rd_est) begin
                  if (eot_q) st_q <= ST_DONE;
                  else begin
                     st_q    <= ST_FETCH0;
                     mreq_q  <= 1'b1;
                     mbe_q   <= 4'hf;
                     maddr_q <= tbl_q;
                  end
               end
               ST_DONE: st_q <= ST_DONE;                    // Held until disabled
               default: st_q <= ST_IDLE;
            endcase
         end
      end
   end

   // Link side on the codec clock: configuration and command toggle synchronisers
   always_ff @(posedge bit_clk or posedge sys_rst) begin
      if (sys_rst) begin
         {ctg_s1_q, ctg_s2_q} <= 2'b00;
         sel_s1_q <= 2'b00;
         sel_s2_q <= 2'b00;
      end else begin
         ctg_s1_q <= cmd_tgl_q;
         ctg_s2_q <= ctg_s1_q;
         sel_s1_q <= cst_q[B_RX_SLOT:B_TX_SLOT];
         sel_s2_q <= sel_s1_q;
      end
   end

   // Per frame: capture input, announce the frame, load the next output words.
   // System words read here settle a few clk cycles after the previous frame,
   // long before this one, so they act as a handshake across the domains.
   always_ff @(posedge bit_clk or posedge sys_rst) begin
      if (sys_rst) begin
         frm_tgl_q <= 1'b0;
         cmd_ack_q <= 1'b0;
         rx_q      <= '0;
         tx_q      <= '0;
      end else begin
         if (lnk_frame) begin
            tx_q.rx_s11 <= sel_s2_q[1];              // Slot choice moves only at a frame
            tx_q.tx_s11 <= sel_s2_q[0];
            rx_q      <= lnk_rx;
            frm_tgl_q <= ~frm_tgl_q;
            tx_q.gpio <= gsnap_q;
            tx_q.smp  <= txs_q;
            tx_q.cmd_vld <= ctg_s2_q != cmd_ack_q;
            if (ctg_s2_q != cmd_ack_q) begin
               cmd_ack_q     <= ctg_s2_q;
               tx_q.cmd_addr <= cmd_q[31:24];
               tx_q.cmd_cdc  <= cmd_q[23:22];
               tx_q.cmd_data <= cmd_q[15:0];
            end
         end
      end
   end

   assign reg_rdata      = rdata_q;
   assign mem_req        = mreq_q;
   assign mem_we         = mwe_q;
   assign mem_addr       = maddr_q;
   assign mem_be         = mbe_q;
   assign mem_wdata      = mwd_q;
   assign mgmt_interrupt = irq_q;
   assign lnk_tx         = tx_q;
endmodule : adcp_top

// [testbench/adcp_props.sv]
// Pin-level checks for adcp_top: memory handshake, register reads, link.
// Assumes the bench keeps one idle cycle between register strobes.
`timescale 1ns/10ps
module adcp_props
   import adcp_pkg::*;
(
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        mem_req,
   input wire logic        mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [3:0]  mem_be,
   input wire logic [31:0] mem_wdata,
   input wire logic        mem_ack,
   input wire logic        mgmt_interrupt,
   input wire logic        bit_clk,
   input wire logic        lnk_frame,
   input wire adcp_tx_t    lnk_tx
);
   req_hold_a: assert property (
      @(posedge clk) disable iff (sys_rst) mem_req && !mem_ack |=> mem_req && $stable({mem_addr, mem_we, mem_be}))
      else $error("memory request moved before ack");
   desc_step_a: assert property (
      @(posedge clk) disable iff (sys_rst) mem_req && mem_ack && mem_be == 4'hf && !mem_we
      |=> !mem_req || mem_be != 4'hf || mem_addr == $past(mem_addr) + 32'h4) else $error("second word not at +4");
   irq_pulse_a: assert property (
      @(posedge clk) disable iff (sys_rst) mgmt_interrupt |=> !mgmt_interrupt) else $error("interrupt not a pulse");
   cmd_pend_a: assert property (
      @(posedge clk) disable iff (sys_rst) reg_wr && reg_addr == OFS_CDC_CMD ##2 reg_rd && reg_addr == OFS_CDC_CMD
      |=> reg_rdata[B_CMD_VLD]) else $error("command valid not set on load");
   tbl_low_a: assert property (
      @(posedge clk) disable iff (sys_rst) reg_rd && reg_addr == OFS_ENG_TBL |=> reg_rdata[1:0] == 2'b00)
      else $error("table address low bits set");
   wr_dup_a: assert property (
      @(posedge clk) disable iff (sys_rst) mem_req && mem_we |-> mem_be != 4'hf && mem_wdata[31:16] == mem_wdata[15:0])
      else $error("bad sample write");
   tx_hold_a: assert property (
      @(posedge bit_clk) disable iff (sys_rst) !lnk_frame |=> $stable(lnk_tx)) else $error("link word moved mid-frame");
   cmd_once_a: assert property (
      @(posedge bit_clk) disable iff (sys_rst) lnk_tx.cmd_vld && lnk_frame |=> !lnk_tx.cmd_vld)
      else $error("command sent twice");
   // Main scenarios reached
   cover property (@(posedge clk) disable iff (sys_rst) mgmt_interrupt);
   cover property (@(posedge clk) disable iff (sys_rst) mem_req && mem_we && mem_ack);
   cover property (@(posedge bit_clk) disable iff (sys_rst) lnk_tx.cmd_vld);
endmodule : adcp_props

bind adcp_top adcp_props u_props (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
   .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mgmt_interrupt(mgmt_interrupt),
   .bit_clk(bit_clk), .lnk_frame(lnk_frame), .lnk_tx(lnk_tx));

// [testbench/adcp_far.sv]
// Far side: system memory answering the engine, and the codec that owns
// the link clock and sends one frame every eight bit clocks.
`timescale 1ns/10ps
module adcp_far
   import adcp_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        slow,      // Stretch memory answers
   input  wire logic        stat_en,   // Tag status slots valid
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [31:0] mem_addr,
   input  wire logic [3:0]  mem_be,
   input  wire logic [31:0] mem_wdata,
   output logic             mem_ack,
   output logic      [31:0] mem_rdata,
   output logic             bit_clk,
   output logic             lnk_frame,
   output adcp_rx_t         lnk_rx
);
   logic [31:0] mem [256];  // Word store on address bits 9:2
   logic [1:0]  wait_q;     // Cycles left before an answer
   logic [2:0]  bc_q;       // Bit clock within frame
   adcp_rx_t    rx;         // Frame content
   // Status address 5a, data 1234, GPIO pins abcd, sample beef
   assign rx = '{stat_en, stat_en, 1'b1, 20'h5a000, 20'h12340, 20'h0abcd, 20'hbeef0};
   // The codec owns the link clock, free running as on a real codec
   initial begin
      {mem_ack, mem_rdata, wait_q, bc_q, lnk_frame, lnk_rx} = '0;
      foreach (mem[i]) mem[i] = 32'h0;
      bit_clk = 1'b0;
      #17;
      forever #62.5 bit_clk = ~bit_clk;
   end
   // One answer per request, never in the cycle straight after an answer
   always @(posedge clk) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;  // Stale data never looks valid
      if (mem_req && !mem_ack) begin
         wait_q <= wait_q - 2'h1;
         if (wait_q == 2'h0) begin
            mem_ack <= 1'b1;
            wait_q <= slow ? 2'h3 : 2'h0;
            mem_rdata <= mem[mem_addr[9:2]];
            for (int b = 0; b < 4; b++)
               if (mem_we && mem_be[b]) mem[mem_addr[9:2]][8*b +: 8] <= mem_wdata[8*b +: 8];
         end
      end
   end
   // Slots are valid only with the frame flag; inverted in between
   always @(posedge bit_clk) begin
      bc_q <= bc_q + 3'h1;
      lnk_frame <= (bc_q == 3'h7);
      lnk_rx <= (bc_q == 3'h7) ? rx : adcp_rx_t'(~rx);
   end
endmodule : adcp_far

// [testbench/testbench.sv]
// Self-checking bench for adcp_top: registers, codec slots, engine walk.
// The far-side model supplies memory and the codec link.
`timescale 1ns/10ps
module testbench;
   import adcp_pkg::*;
   logic        clk, sys_rst, reg_wr, reg_rd, mem_req, mem_we, mem_ack, mgmt_interrupt;
   logic        bit_clk, lnk_frame, stat_en, slow;
   logic [7:0]  reg_addr;
   logic [3:0]  mem_be;
   logic [31:0] reg_wdata, reg_rdata, mem_addr, mem_wdata, mem_rdata, cw;
   adcp_rx_t    lnk_rx;
   adcp_tx_t    lnk_tx;
   logic [32:0] exp_q [$];  // Expected accesses: write flag, address
   int          err_count, samples_checked, irq_n;
   localparam logic [7:0]  RA [5] = '{OFS_GPIO_STAT, OFS_GPIO_CTL, OFS_CDC_STAT, OFS_CDC_CMD, 8'h10};
   localparam int          DI [11] = '{64, 65, 66, 67, 68, 69, 72, 73, 80, 81, 192};
   // Table: two end-of-page entries, a jump, an end entry; a lone input entry; sample word
   localparam logic [31:0] DT [11] = '{32'h200, 32'h4000_0004, 32'h302, 32'h4000_0002, 32'h120,
      32'h2000_0000, 32'h400, 32'h8000_0002, 32'h380, 32'h8000_0002, 32'hc3c3_5a5a};

   adcp_top DUT (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .mgmt_interrupt(mgmt_interrupt), .bit_clk(bit_clk), .lnk_frame(lnk_frame), .lnk_rx(lnk_rx), .lnk_tx(lnk_tx));
   adcp_far far (.clk(clk), .slow(slow), .stat_en(stat_en), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .bit_clk(bit_clk), .lnk_frame(lnk_frame), .lnk_rx(lnk_rx));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   // Data lands on the edge that takes the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(nm, e, reg_rdata);
   endtask : rd
   task automatic frames(input int n);
      repeat (n * 8) @(posedge bit_clk);
      #1;
   endtask : frames
   task automatic wait_mem();
      for (int i = 0; i < 4000 && exp_q.size() > 0; i++) @(posedge clk);
      if (exp_q.size() != 0) begin
         chk("mem_wait", 32'h0, 32'(exp_q.size()));
         end_of_test();
      end
   endtask : wait_mem

   // Every memory access is matched against the expected walk, extras too
   always @(posedge clk) begin
      if (mgmt_interrupt === 1'b1) irq_n++;
      if (mem_req === 1'b1 && mem_ack === 1'b1) begin
         if (exp_q.size() == 0) chk("mem_extra", 32'h0, mem_addr);
         else begin
            chk("mem_addr", exp_q[0][31:0], mem_addr & 32'hffff_fffc);
            chk("mem_we", {31'h0, exp_q[0][32]}, {31'h0, mem_we});
            if (exp_q[0][32]) chk("mem_wdata", 32'hbeef_beef, mem_wdata);
            void'(exp_q.pop_front());
         end
      end
   end

   initial begin
      {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata, stat_en, slow} = {1'b1, 44'h0};
      #1 foreach (DT[i]) far.mem[DI[i]] = DT[i];
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      foreach (RA[i]) rd(RA[i], i == 0 ? RST_GPIO_STAT : RST_ZERO, "reset_value");
      wr(OFS_GPIO_CTL, 32'h000a_bcde);
      wr(OFS_CDC_STAT, 32'hffff_ffff);
      stat_en <= 1'b1;
      frames(2);
      stat_en <= 1'b0;
      frames(2);
      chk("gpio_out", 32'h000a_bcde, {12'h0, lnk_tx.gpio});
      chk("slot_sel", 32'h3, {30'h0, lnk_tx.tx_s11, lnk_tx.rx_s11});
      rd(OFS_GPIO_STAT, 32'h0000_abcd, "gpio_in");
      rd(OFS_CDC_STAT, 32'h5afb_1234, "status_new");
      rd(OFS_CDC_STAT, 32'h5af9_1234, "status_old");
      wr(OFS_CDC_STAT, 32'h0);
      frames(2);
      chk("slot_sel", 32'h0, {30'h0, lnk_tx.tx_s11, lnk_tx.rx_s11});
      // Only the primary and secondary codec are ever addressed
      for (int c = 0; c < 2; c++) begin
         cw = {8'h5a ^ 8'(c), 2'(c), 6'h0, 16'h1234};
         wr(OFS_CDC_CMD, cw);
         rd(OFS_CDC_CMD, cw | 32'h0001_0000, "cmd_pending");
         for (int i = 0; i < 40 && lnk_tx.cmd_vld !== 1'b1; i++) begin
            @(posedge bit_clk);
            #1;
         end
         chk("cmd_out", {5'h0, 1'b1, cw[31:22], cw[15:0]}, {5'h0, lnk_tx.cmd_vld, lnk_tx.cmd_addr,
            lnk_tx.cmd_cdc, lnk_tx.cmd_data});
         if (lnk_tx.cmd_vld !== 1'b1) end_of_test();
         frames(2);
         rd(OFS_CDC_CMD, cw, "cmd_sent");
      end
      // Start in order: table, address, status clear, direction, enable
      wr(OFS_ENG_TBL, 32'h100);
      rd(OFS_ENG_CTL, 32'h0, "eng_clear");
      wr(OFS_ENG_CTL, 32'h0);
      exp_q = '{33'h100, 33'h104, 33'h200, 33'h200, 33'h108, 33'h10c, 33'h300};
      wr(OFS_ENG_CTL, 32'h1);
      wait_mem();
      frames(3);
      chk("smp_out", 32'h0000_c3c3, {16'h0, lnk_tx.smp});
      rd(OFS_ENG_TBL, 32'h110, "tbl_next");
      chk("irq_count", 32'h1, 32'(irq_n));
      exp_q = '{33'h110, 33'h114, 33'h120, 33'h124, 33'h400};
      rd(OFS_ENG_CTL, 32'h301, "eng_error");
      wait_mem();
      frames(2);
      rd(OFS_ENG_CTL, 32'h1, "eng_end");
      rd(OFS_ENG_TBL, 32'h128, "tbl_jump");
      // Disable only at end of table, then an input run on slow memory
      slow <= 1'b1;
      wr(OFS_ENG_CTL, 32'h0);
      wr(OFS_ENG_TBL, 32'h140);
      rd(OFS_ENG_CTL, 32'h0, "eng_clear");
      exp_q = '{33'h140, 33'h144, 33'h1_0000_0380};
      wr(OFS_ENG_CTL, 32'h8);
      wr(OFS_ENG_CTL, 32'h9);
      wait_mem();
      frames(2);
      rd(OFS_ENG_CTL, 32'h9, "eng_end_in");
      end_of_test();
   end
endmodule : testbench
